// ===== logic/dac_link_pkg.sv
// shared constants and types for the dual converter serial link
package dac_link_pkg;
  localparam int WORD_BITS = 16;
  localparam int CTRL_BITS = 4;
  localparam int CODE_BITS = 10;
  localparam int CTRL_MSB  = 15;
  localparam int CODE_MSB  = 11;
  localparam int CODE_LSB  = 2;
  localparam int BIT_CNT_W = 5;
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // serial clock divider: half period in system cycles
  localparam int SCK_HALF_NS     = 64;
  localparam int SYS_PERIOD_NS   = 8;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [4:0] BIT_CNT_RESET   = 5'h00;
  localparam logic [2:0] SYNC_HIGH_RESET = 3'h7;
  localparam logic [2:0] SYNC_LOW_RESET  = 3'h0;
  localparam logic [1:0] DATA_SYNC_RESET = 2'h0;
  localparam logic       AWAKE_RESET     = 1'b1;

  typedef enum logic [3:0] {
    CMD_NOP       = 4'h0,
    CMD_LOAD_A    = 4'h1,
    CMD_LOAD_B    = 4'h2,
    CMD_UPD_ALL   = 4'h8,
    CMD_LOAD_A_UP = 4'h9,
    CMD_LOAD_B_UP = 4'hA,
    CMD_WAKE      = 4'hD,
    CMD_SLEEP     = 4'hE,
    CMD_LOAD_BOTH = 4'hF
  } ctrl_code_t;
endpackage : dac_link_pkg

// ===== logic/dac_link_if.sv
// three-wire serial link between host master and converter front end
`timescale 1ns/1ps
interface dac_link_if;
  logic load_strobe_n;
  logic sck;
  logic sdi;
  modport host (output load_strobe_n, output sck, output sdi);
  modport device (input load_strobe_n, input sck, input sdi);
endinterface : dac_link_if

// ===== logic/dac_front_end.sv
// converter front end: serial shifter, command decode, input and converter registers
//
// Contract
// - shift only while strobe low
// - strobe rise executes held control code
// - sample data on serial clock rise
// - word is control, code, two pad bits
// - control first, msb first, pads last
// - two input and two converter registers
// - only converter registers drive outputs
// - both converter registers update together
// - output equals code over 1024 times reference
// - reset clears outputs to zero scale
// - code 1110 sleeps, registers kept
// - sleep ignores conversion code field
// - wake restores retained converter values
// - load while asleep, 1000 wakes and updates
// - host holds clock low at strobe fall
// - host raises strobe after sixteen bits
// - 0001/0010 load one input register only
// - 1000/1001/1010 wake and update both
// - 1101 only wakes
// - 1111 loads both, updates, wakes
`timescale 1ns/1ps
module dac_front_end #(
  parameter int CODE_W = dac_link_pkg::CODE_BITS
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  dac_link_if.device             link,
  output logic [CODE_W-1:0]      analog_out_first,
  output logic [CODE_W-1:0]      analog_out_second,
  output logic                   analog_enable,
  output logic                   word_done
);
  // ==========================================================
  // command decode
  typedef struct packed {
    logic load_a;
    logic load_b;
    logic update;
    logic wake;
    logic sleep;
  } cmd_act_t;

  // actions of one control code; unlisted codes do nothing
  function automatic cmd_act_t decode_ctrl(input logic [3:0] code);
    cmd_act_t act_v;
    act_v = '0;
    case (code)
      dac_link_pkg::CMD_NOP: begin
        act_v = '0;
      end
      dac_link_pkg::CMD_LOAD_A: begin
        act_v.load_a = 1'b1;
      end
      dac_link_pkg::CMD_LOAD_B: begin
        act_v.load_b = 1'b1;
      end
      dac_link_pkg::CMD_UPD_ALL: begin
        act_v.update = 1'b1;
        act_v.wake   = 1'b1;
      end
      dac_link_pkg::CMD_LOAD_A_UP: begin
        act_v.load_a = 1'b1;
        act_v.update = 1'b1;
        act_v.wake   = 1'b1;
      end
      dac_link_pkg::CMD_LOAD_B_UP: begin
        act_v.load_b = 1'b1;
        act_v.update = 1'b1;
        act_v.wake   = 1'b1;
      end
      dac_link_pkg::CMD_WAKE: begin
        act_v.wake = 1'b1;
      end
      dac_link_pkg::CMD_SLEEP: begin
        act_v.sleep = 1'b1;
      end
      dac_link_pkg::CMD_LOAD_BOTH: begin
        act_v.load_a = 1'b1;
        act_v.load_b = 1'b1;
        act_v.update = 1'b1;
        act_v.wake   = 1'b1;
      end
      default: begin
        act_v = '0;
      end
    endcase
    return act_v;
  endfunction : decode_ctrl

  // rising edge seen on the synchronised copy of a pin
  function automatic logic sync_rose(input logic [2:0] taps);
    return taps[1] & ~taps[2];
  endfunction : sync_rose

  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0]          cs_sync;
    logic [2:0]          sck_sync;
    logic [1:0]          sdi_sync;
    logic [15:0]         shift;
    logic [CODE_W-1:0]   in_a;
    logic [CODE_W-1:0]   in_b;
    logic [CODE_W-1:0]   dac_a;
    logic [CODE_W-1:0]   dac_b;
    logic                awake;
    logic                done;
  } fe_state_t;

  fe_state_t st_r;
  fe_state_t st_nxt;
  logic [CODE_W-1:0] new_code;
  logic [3:0]        ctrl;
  cmd_act_t          act;

  assign new_code = st_r.shift[dac_link_pkg::CODE_MSB:dac_link_pkg::CODE_LSB];
  assign ctrl     = st_r.shift[dac_link_pkg::CTRL_MSB -: dac_link_pkg::CTRL_BITS];
  assign act      = decode_ctrl(ctrl);

  // ==========================================================
  // next state
  always_comb begin
    st_nxt          = st_r;
    st_nxt.done     = 1'b0;
    // sync stage 0 only feeds stage 1
    st_nxt.cs_sync  = {st_r.cs_sync[1:0], link.load_strobe_n};
    st_nxt.sck_sync = {st_r.sck_sync[1:0], link.sck};
    st_nxt.sdi_sync = {st_r.sdi_sync[0], link.sdi};
    if (!st_r.cs_sync[1] && sync_rose(st_r.sck_sync)) begin
      st_nxt.shift = {st_r.shift[14:0], st_r.sdi_sync[1]};
    end
    if (sync_rose(st_r.cs_sync)) begin
      st_nxt.done = 1'b1;
      if (act.load_a) begin
        st_nxt.in_a = new_code;
      end
      if (act.load_b) begin
        st_nxt.in_b = new_code;
      end
      // both converter registers copy together, after any load of this word
      if (act.update) begin
        st_nxt.dac_a = st_nxt.in_a;
        st_nxt.dac_b = st_nxt.in_b;
      end
      if (act.wake) begin
        st_nxt.awake = 1'b1;
      end
      if (act.sleep) begin
        st_nxt.awake = 1'b0;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r.cs_sync  <= dac_link_pkg::SYNC_HIGH_RESET;
      st_r.sck_sync <= dac_link_pkg::SYNC_LOW_RESET;
      st_r.sdi_sync <= dac_link_pkg::DATA_SYNC_RESET;
      st_r.shift    <= dac_link_pkg::WORD_RESET;
      st_r.in_a     <= dac_link_pkg::CODE_RESET;
      st_r.in_b     <= dac_link_pkg::CODE_RESET;
      st_r.dac_a    <= dac_link_pkg::CODE_RESET;
      st_r.dac_b    <= dac_link_pkg::CODE_RESET;
      st_r.awake    <= dac_link_pkg::AWAKE_RESET;
      st_r.done     <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs are converter codes (k/1024 of reference); only converter regs drive them
  assign analog_out_first  = st_r.dac_a;
  assign analog_out_second = st_r.dac_b;
  assign analog_enable     = st_r.awake;
  assign word_done         = st_r.done;
endmodule : dac_front_end

// ===== logic/dac_host_master.sv
// host serial master: sends one 16-bit command word per request
`timescale 1ns/1ps
module dac_host_master #(
  parameter int HALF_CYCLES = dac_link_pkg::SCK_HALF_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_ctrl,
  input  wire logic [9:0]  req_code,
  output logic             req_ready,
  dac_link_if.host         link
);
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_SHIFT = 2'b11,
    H_LOAD  = 2'b10
  } host_st_t;

  typedef struct packed {
    host_st_t    st;
    logic [7:0]  div;
    logic [15:0] word;
    logic [4:0]  bits;
    logic        sck;
    logic        cs_n;
    logic        ready;
  } host_state_t;

  host_state_t s_r;
  host_state_t s_nxt;
  logic        tick;

  assign tick = (s_r.div == 8'(HALF_CYCLES - 1));

  // ==========================================================
  // sequencer
  always_comb begin
    s_nxt     = s_r;
    s_nxt.div = tick ? dac_link_pkg::DIV_RESET : s_r.div + 8'h01;
    case (s_r.st)
      H_IDLE: begin
        s_nxt.div = dac_link_pkg::DIV_RESET;
        if (req_valid && s_r.ready) begin
          s_nxt.word  = {req_ctrl, req_code, 2'b00};
          s_nxt.bits  = dac_link_pkg::BIT_CNT_RESET;
          s_nxt.sck   = 1'b0; // clock low before strobe falls
          s_nxt.cs_n  = 1'b0;
          s_nxt.ready = 1'b0;
          s_nxt.st    = H_SETUP;
        end
      end
      H_SETUP: if (tick) s_nxt.st = H_SHIFT;
      H_SHIFT: if (tick) begin
        if (!s_r.sck) begin
          s_nxt.sck = 1'b1;
          s_nxt.bits = s_r.bits + 5'h01;
        end else begin
          s_nxt.sck  = 1'b0;
          s_nxt.word = {s_r.word[14:0], 1'b0};
          if (s_r.bits == 5'(dac_link_pkg::WORD_BITS)) s_nxt.st = H_LOAD;
        end
      end
      H_LOAD: if (tick) begin
        // strobe rises only after all sixteen bits, then stays high a half period
        if (!s_r.cs_n) begin
          s_nxt.cs_n = 1'b1;
        end else begin
          s_nxt.ready = 1'b1;
          s_nxt.st    = H_IDLE;
        end
      end
      default: begin
        s_nxt.cs_n  = 1'b1;
        s_nxt.sck   = 1'b0;
        s_nxt.ready = 1'b1;
        s_nxt.st    = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r.st    <= H_IDLE;
      s_r.div   <= dac_link_pkg::DIV_RESET;
      s_r.word  <= dac_link_pkg::WORD_RESET;
      s_r.bits  <= dac_link_pkg::BIT_CNT_RESET;
      s_r.sck   <= 1'b0;
      s_r.cs_n  <= 1'b1;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.load_strobe_n = s_r.cs_n;
  assign link.sck           = s_r.sck;
  assign link.sdi           = s_r.word[15];
  assign req_ready          = s_r.ready;
endmodule : dac_host_master

// ===== sim/dac_link_asserts.sv
// assertions on the serial link and front end outputs
`timescale 1ns/1ps
module dac_link_asserts (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       load_strobe_n,
  input wire logic       sck,
  input wire logic       sdi,
  input wire logic       word_done,
  input wire logic       analog_enable,
  input wire logic [9:0] analog_out_first,
  input wire logic [9:0] analog_out_second
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ===========================================
  // rising serial clock edges within a frame
  logic [4:0] rises_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || $fell(load_strobe_n)) rises_r <= 5'h00;
    else if ($rose(sck)) rises_r <= rises_r + 5'h01;
  end
  property p_start; $fell(load_strobe_n) |-> !sck; endproperty
  a_start: assert property (p_start)
    else $error("sck high at frame start");
  property p_count; $rose(load_strobe_n) |-> rises_r == 5'h10; endproperty
  a_count: assert property (p_count)
    else $error("frame not sixteen bits");
  property p_idle; load_strobe_n |-> !sck; endproperty
  a_idle: assert property (p_idle)
    else $error("sck moves between frames");
  property p_data; $rose(sck) |-> $stable(sdi); endproperty
  a_data: assert property (p_data)
    else $error("sdi moves at sck rise");
  property p_exec; $rose(load_strobe_n) |-> ##[2:5] word_done; endproperty
  a_exec: assert property (p_exec)
    else $error("no execution after strobe");
  property p_pulse; word_done |=> !word_done; endproperty
  a_pulse: assert property (p_pulse)
    else $error("done longer than one cycle");
  property p_outs; !word_done |-> $stable({analog_out_first, analog_out_second}); endproperty
  a_outs: assert property (p_outs)
    else $error("outputs moved without command");
  property p_en; !word_done |-> $stable(analog_enable); endproperty
  a_en: assert property (p_en)
    else $error("enable moved without command");
  c_sleep: cover property (word_done && !analog_enable);
  c_wake: cover property ($rose(analog_enable));
  c_frame: cover property ($rose(load_strobe_n));
endmodule : dac_link_asserts

// ===== sim/test_dual_dac_serial_control.sv
// bench: host master driving front end, plus a hand-driven faulty link
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_dual_dac_serial_control;
  logic        clk_sys, rst_n, req_valid, req_ready, word_done, analog_enable, awake;
  logic [3:0]  req_ctrl;
  logic [9:0]  req_code, in_a, in_b, dac_a, dac_b, out_a, out_b, out2;
  logic [20:0] exp_w;
  logic [20:0] exp_q[$];
  logic [3:0]  seq[6] = '{4'hE, 4'h1, 4'h2, 4'hD, 4'hE, 4'h8};
  int          err_count, compares, seed;
  dac_link_if link();
  dac_link_if link2();
  dac_host_master dac_host_master_inst (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req_ctrl(req_ctrl), .req_code(req_code), .req_ready(req_ready), .link(link.host));
  dac_front_end dac_front_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.device),
    .analog_out_first(out_a), .analog_out_second(out_b), .analog_enable(analog_enable),
    .word_done(word_done));
  dac_front_end dac_front_end_inst_b (.clk_sys(clk_sys), .rst_n(rst_n), .link(link2.device),
    .analog_out_first(out2), .analog_out_second(), .analog_enable(), .word_done());
  dac_link_asserts dac_link_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .load_strobe_n(link.load_strobe_n), .sck(link.sck), .sdi(link.sdi), .word_done(word_done),
    .analog_enable(analog_enable), .analog_out_first(out_a), .analog_out_second(out_b));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic results;
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // ===========================================
  // one host request plus the expected outcome
  task automatic send(input logic [3:0] c, input logic [9:0] d);
    int n;
    @(negedge clk_sys);
    req_ctrl = c;
    req_code = d;
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    case (c)
      4'h1, 4'h9: in_a = d;
      4'h2, 4'hA: in_b = d;
      4'hF: begin
        in_a = d;
        in_b = d;
      end
      default: ;
    endcase
    if (c inside {4'h8, 4'h9, 4'hA, 4'hF}) begin
      dac_a = in_a;
      dac_b = in_b;
    end
    if (c inside {4'h8, 4'h9, 4'hA, 4'hD, 4'hF}) awake = 1'b1;
    if (c == 4'hE) awake = 1'b0;
    exp_q.push_back({awake, dac_a, dac_b});
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    if (req_ready !== 1'b1) err_count++;
  endtask : send
  task automatic drive2(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      link2.sdi = w[i];
      #32 link2.sck = 1'b1;
      #32 link2.sck = 1'b0;
    end
  endtask : drive2
  always @(negedge clk_sys) begin
    if (word_done === 1'b1) begin
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK({analog_enable, out_a, out_b}, exp_w)
    end
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    results();
  end
  initial begin
    seed = 32'h0000_ed46;
    {rst_n, req_valid, req_ctrl, req_code} = '0;
    {link2.load_strobe_n, link2.sck, link2.sdi} = 3'b100;
    {in_a, in_b, dac_a, dac_b, awake} = {40'h00_0000_0000, 1'b1};
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    `CHK({analog_enable, out_a, out_b}, 21'h10_0000)
    for (int c = 0; c < 16; c++) send(c[3:0], 10'($random(seed)));
    $display("code sweep done");
    foreach (seq[i]) send(seq[i], 10'($random(seed)));
    repeat (20) @(negedge clk_sys);
    $display("sleep test done");
    drive2(16'hffff);
    link2.load_strobe_n = 1'b0;
    #64 link2.load_strobe_n = 1'b1;
    #200 `CHK(out2, 10'h000)
    link2.load_strobe_n = 1'b0;
    drive2({4'hF, 10'h2c5, 2'b01});
    link2.sdi = 1'b0;
    #32 link2.load_strobe_n = 1'b1;
    #200 `CHK(out2, 10'h2c5)
    $display("faulty link test done");
    results();
  end
endmodule : test_dual_dac_serial_control
